// *** rtl/irq_timebase.sv ***
// Interrupt request flags, enable gating, vectoring and two time bases.
// Assumes same-clock peripheral event pulses, a core that accepts a vector
// at instruction boundaries, and an asynchronous sub clock on a pin.
//
// How it works
// - Time base counts only while run bit set
// - Period code selects 2^(8+code) prescaler clocks
// - Each timer has A and P match flags
// - Timer vector needs global, own, group enable
// - Timer service clears global and group flag only
// - Serial flag set on byte, address, time-out
// - Serial vector clears serial flag and global
// - UART flag set by any of six conditions
// - UART vector clears UART flag and global
// - Low supply flag vectors via gated group
// - Low supply service clears group flag, global
// - NVM done flag vectors via gated group
// - NVM service clears group flag and global
// - Any rising flag wakes, enables ignored
// - Flags hold until serviced or cleared
// - Vector only when stack not full
// - Vectoring pushes only the program counter
// - Return-from-irq sets global; plain return leaves it
// - Prescaler source: system, system/4, sub clock
// - Group flag set on a member event or by a software preset
// - Time base overflow sets its own flag
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module irq_timebase (
  // Clock, reset, clock enable
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic        clk_en,
  // AXI4-Lite write address
  input  wire  logic        awvalid,
  output logic              awready,
  input  wire  logic [7:0]  awaddr,
  input  wire  logic [2:0]  awprot,
  // AXI4-Lite write data
  input  wire  logic        wvalid,
  output logic              wready,
  input  wire  logic [31:0] wdata,
  input  wire  logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic              bvalid,
  input  wire  logic        bready,
  output logic [1:0]        bresp,
  // AXI4-Lite read address
  input  wire  logic        arvalid,
  output logic              arready,
  input  wire  logic [7:0]  araddr,
  input  wire  logic [2:0]  arprot,
  // AXI4-Lite read data
  output logic              rvalid,
  input  wire  logic        rready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  // Sub clock pin, asynchronous
  input  wire  logic        sub_clk,
  // Peripheral event pulses
  input  wire  logic [1:0]  tm_match_a,
  input  wire  logic [1:0]  tm_match_p,
  input  wire  logic [2:0]  serial_if_event,
  input  wire  logic [5:0]  uart_event,
  input  wire  logic        low_supply_detect,
  input  wire  logic        nvm_cycle_done,
  // Processor core side
  input  wire  logic        instr_boundary,
  input  wire  logic        stack_full,
  input  wire  logic        return_from_irq,
  input  wire  logic        plain_return,
  output logic              vector_call,
  output logic [2:0]        vector_id,
  output logic              pc_pop,
  output logic              wake_req
);

  // Whole block state
  typedef struct packed {
    logic             aw_held;   // Write address captured
    logic [7:0]       aw_addr;   // Captured write address
    logic             w_held;    // Write data captured
    logic [31:0]      w_data;    // Captured write data
    logic [3:0]       w_strb;    // Captured byte strobes
    logic             bvalid;    // Write response pending
    logic [1:0]       bresp;     // Write response code
    logic             rvalid;    // Read data pending
    logic [31:0]      rdata;     // Read data
    logic [1:0]       rresp;     // Read response code
    logic [1:0][7:0]  tb_ctrl;   // Time base control registers
    logic [3:0]       psc_src;   // Prescaler sources, two bits each
    logic [15:0]      enables;   // Enable bits incl. global
    logic [15:0]      flags;     // Request flags
    logic [1:0]       div4;      // System clock divide-by-four
    logic [2:0]       sub_sync;  // Sub clock synchroniser
    logic             sub_level; // Settled sub clock level
    logic [1:0][14:0] tb_cnt;    // Time base counters
    logic             vec_call;  // Vector call pulse
    logic [2:0]       vec_id;    // Vector taken
    logic             pc_pop;    // Return pulse
    logic             wake;      // Wake-up pulse
  } state_s;

  // Reset image
  localparam state_s ST_RESET = '{
    tb_ctrl : {irq_tb_pkg::TB_CTRL_RESET, irq_tb_pkg::TB_CTRL_RESET},
    psc_src : irq_tb_pkg::PSC_SRC_RESET,
    enables : irq_tb_pkg::ENABLE_RESET,
    flags   : irq_tb_pkg::FLAG_RESET,
    vec_id  : irq_tb_pkg::VEC_NONE,
    default : '0
  };

  state_s st_q; // Registered state
  state_s st_d; // Next state

  // Byte-lane merge for the low 16 bits of a register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Handshake outputs; frozen with the clock enable
  assign awready = clk_en & ~st_q.aw_held;
  assign wready  = clk_en & ~st_q.w_held;
  assign arready = clk_en & ~st_q.rvalid;
  // Registered outputs
  assign bvalid      = st_q.bvalid;
  assign bresp       = st_q.bresp;
  assign rvalid      = st_q.rvalid;
  assign rdata       = st_q.rdata;
  assign rresp       = st_q.rresp;
  assign vector_call = st_q.vec_call;
  assign vector_id   = st_q.vec_id;
  assign pc_pop      = st_q.pc_pop;
  assign wake_req    = st_q.wake;

  // Next-state logic
  always_comb begin
    logic        sub_rise;
    logic [1:0]  tick;
    logic [1:0]  tb_evt;
    logic [2:0]  period;
    logic [14:0] last;
    logic [15:0] set_evt;
    logic [15:0] sw_set;
    logic [15:0] sw_clr;
    logic [15:0] hw_clr;
    logic [15:0] en_new;
    logic [6:0]  req;
    logic        do_write;
    logic        hit;
    logic [31:0] rd;
    sub_rise = 1'b0;
    tick     = 2'h0;
    tb_evt   = 2'h0;
    period   = 3'h0;
    last     = 15'h0000;
    set_evt  = 16'h0000;
    sw_set   = 16'h0000;
    sw_clr   = 16'h0000;
    hw_clr   = 16'h0000;
    en_new   = st_q.enables;
    req      = 7'h00;
    do_write = 1'b0;
    hit      = 1'b0;
    rd       = 32'h0000_0000;
    st_d     = st_q;
    st_d.vec_call = 1'b0;
    st_d.pc_pop   = 1'b0;
    st_d.wake     = 1'b0;

    // Sub clock: three flops, a level change counts when two agree
    st_d.sub_sync = {st_q.sub_sync[1:0], sub_clk};
    if (st_q.sub_sync[2] == st_q.sub_sync[1]) begin
      st_d.sub_level = st_q.sub_sync[2];
      sub_rise = st_q.sub_sync[2] & ~st_q.sub_level;
    end
    // Free-running quarter-rate divider
    st_d.div4 = st_q.div4 + 2'h1;

    // Time base generators
    for (int i = 0; i < 2; i++) begin
      // Prescaler tick source
      case (st_q.psc_src[2*i +: 2])
        irq_tb_pkg::PSC_SYS:      tick[i] = 1'b1;
        irq_tb_pkg::PSC_SYS_DIV4: tick[i] = st_q.div4 == irq_tb_pkg::DIV4_LAST;
        default:                  tick[i] = sub_rise;
      endcase
      // Terminal count 2^(8+code)-1
      period = st_q.tb_ctrl[i][irq_tb_pkg::TB_PERIOD_LSB +: 3];
      last   = irq_tb_pkg::TB_CNT_FULL >> (irq_tb_pkg::TB_PERIOD_MAX - period);
      if (!st_q.tb_ctrl[i][irq_tb_pkg::TB_RUN_BIT]) begin
        // Stopped generator holds at zero
        st_d.tb_cnt[i] = 15'h0000;
      end else if (tick[i]) begin
        if (st_q.tb_cnt[i] >= last) begin
          // Overflow
          st_d.tb_cnt[i] = 15'h0000;
          tb_evt[i] = 1'b1;
        end else begin
          st_d.tb_cnt[i] = st_q.tb_cnt[i] + 15'h0001;
        end
      end
    end

    // Source events
    set_evt[irq_tb_pkg::BIT_TB0]    = tb_evt[0];
    set_evt[irq_tb_pkg::BIT_TB1]    = tb_evt[1];
    set_evt[irq_tb_pkg::BIT_SERIAL] = |serial_if_event;
    set_evt[irq_tb_pkg::BIT_UART]   = |uart_event;
    set_evt[irq_tb_pkg::BIT_TM0A]   = tm_match_a[0];
    set_evt[irq_tb_pkg::BIT_TM0P]   = tm_match_p[0];
    set_evt[irq_tb_pkg::BIT_TM1A]   = tm_match_a[1];
    set_evt[irq_tb_pkg::BIT_TM1P]   = tm_match_p[1];
    set_evt[irq_tb_pkg::BIT_LOWSUP] = low_supply_detect;
    set_evt[irq_tb_pkg::BIT_NVM]    = nvm_cycle_done;
    // Group flags follow their members
    set_evt[irq_tb_pkg::BIT_MF0] = tm_match_a[0] | tm_match_p[0];
    set_evt[irq_tb_pkg::BIT_MF1] = tm_match_a[1] | tm_match_p[1];
    set_evt[irq_tb_pkg::BIT_MF2] = low_supply_detect | nvm_cycle_done;

    // Register write, once address and data are both held
    do_write = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
    if (do_write) begin
      hit = 1'b1;
      case (st_q.aw_addr)
        irq_tb_pkg::OFS_TB0_CTRL: begin
          if (st_q.w_strb[0]) begin
            st_d.tb_ctrl[0] = st_q.w_data[7:0] & irq_tb_pkg::TB_CTRL_MASK;
          end
        end
        irq_tb_pkg::OFS_TB1_CTRL: begin
          if (st_q.w_strb[0]) begin
            st_d.tb_ctrl[1] = st_q.w_data[7:0] & irq_tb_pkg::TB_CTRL_MASK;
          end
        end
        irq_tb_pkg::OFS_PSC_SRC: begin
          if (st_q.w_strb[0]) begin
            st_d.psc_src = st_q.w_data[3:0] & irq_tb_pkg::PSC_SRC_MASK;
          end
        end
        irq_tb_pkg::OFS_ENABLE: begin
          en_new = merge16(st_q.enables, st_q.w_data, st_q.w_strb)
                   & irq_tb_pkg::ENABLE_MASK;
        end
        irq_tb_pkg::OFS_FLAG: begin
          // Software clear
          sw_clr = merge16(16'h0000, st_q.w_data, st_q.w_strb);
        end
        irq_tb_pkg::OFS_FLAG_SET: begin
          // Software preset, used to mask a wake-up source
          sw_set = merge16(16'h0000, st_q.w_data, st_q.w_strb);
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = hit ? irq_tb_pkg::RESP_OKAY : irq_tb_pkg::RESP_SLVERR;
    end

    // Write response retire
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    // Write address and data capture, either order
    if (awvalid && !st_q.aw_held) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && !st_q.w_held) begin
      st_d.w_held = 1'b1;
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
    end

    // Gated requests
    for (int v = 0; v < 4; v++) begin
      req[v] = st_q.flags[v] & st_q.enables[v];
    end
    req[irq_tb_pkg::VEC_MF0] = st_q.flags[irq_tb_pkg::BIT_MF0]
      & st_q.enables[irq_tb_pkg::BIT_MF0]
      & |(st_q.flags[8:7] & st_q.enables[8:7]);
    req[irq_tb_pkg::VEC_MF1] = st_q.flags[irq_tb_pkg::BIT_MF1]
      & st_q.enables[irq_tb_pkg::BIT_MF1]
      & |(st_q.flags[10:9] & st_q.enables[10:9]);
    req[irq_tb_pkg::VEC_MF2] = st_q.flags[irq_tb_pkg::BIT_MF2]
      & st_q.enables[irq_tb_pkg::BIT_MF2]
      & |(st_q.flags[12:11] & st_q.enables[12:11]);

    // Vector call: global enable, boundary, room on the stack
    if (st_q.enables[irq_tb_pkg::BIT_GLOBAL] && instr_boundary &&
        !stack_full && !st_q.vec_call && (|req)) begin
      // Lowest code wins
      for (int v = 6; v >= 0; v--) begin
        if (req[v]) begin
          st_d.vec_id = 3'(v);
        end
      end
      // Only the program counter is pushed by the core
      st_d.vec_call = 1'b1;
      // Clear the vectored flag only; members keep theirs
      hw_clr[st_d.vec_id] = 1'b1;
      en_new[irq_tb_pkg::BIT_GLOBAL] = 1'b0;
    end

    // Returns: return-from-irq re-enables, plain return does not
    if (return_from_irq) begin
      en_new[irq_tb_pkg::BIT_GLOBAL] = 1'b1;
    end
    st_d.pc_pop  = return_from_irq | plain_return;
    st_d.enables = en_new;

    // Flags hold; set wins over clear
    st_d.flags = ((st_q.flags & ~(sw_clr | hw_clr)) | set_evt | sw_set)
                 & irq_tb_pkg::FLAG_MASK;
    // Any flag going high wakes, regardless of enables
    st_d.wake = |(st_d.flags & ~st_q.flags);

    // Register read
    if (arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = irq_tb_pkg::RESP_OKAY;
      case (araddr)
        irq_tb_pkg::OFS_TB0_CTRL: rd = {24'h000000, st_q.tb_ctrl[0]};
        irq_tb_pkg::OFS_TB1_CTRL: rd = {24'h000000, st_q.tb_ctrl[1]};
        irq_tb_pkg::OFS_PSC_SRC:  rd = {28'h0000000, st_q.psc_src};
        irq_tb_pkg::OFS_ENABLE:   rd = {16'h0000, st_q.enables};
        irq_tb_pkg::OFS_FLAG:     rd = {16'h0000, st_q.flags};
        irq_tb_pkg::OFS_FLAG_SET: rd = 32'h0000_0000;
        default: begin
          rd = 32'h0000_0000;
          st_d.rresp = irq_tb_pkg::RESP_SLVERR;
        end
      endcase
      st_d.rdata = rd;
    end else if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire

// *** rtl/irq_tb_pkg.sv ***
// Constants, field layouts and vector codes of the interrupt and time base
// block. Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package irq_tb_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_TB0_CTRL = 8'h00; // Time base zero control
  localparam logic [7:0] OFS_TB1_CTRL = 8'h04; // Time base one control
  localparam logic [7:0] OFS_PSC_SRC  = 8'h08; // Prescaler clock sources
  localparam logic [7:0] OFS_ENABLE   = 8'h0C; // Enable bits
  localparam logic [7:0] OFS_FLAG     = 8'h10; // Flags, write one to clear
  localparam logic [7:0] OFS_FLAG_SET = 8'h14; // Write one to set a flag

  // Time base control fields
  localparam int         TB_RUN_BIT    = 7;        // Generator run bit
  localparam int         TB_PERIOD_LSB = 0;        // Period code position
  localparam logic [7:0] TB_CTRL_MASK  = 8'h87;    // Implemented bits
  localparam logic [7:0] TB_CTRL_RESET = 8'h00;    // Stopped, code 000
  localparam logic [2:0] TB_PERIOD_MAX = 3'h7;     // Code for 2^15
  localparam logic [14:0] TB_CNT_FULL  = 15'h7FFF; // 2^15 - 1

  // Prescaler source field: 00 system, 01 system/4, 1x sub clock
  localparam logic [1:0] PSC_SYS      = 2'h0;
  localparam logic [1:0] PSC_SYS_DIV4 = 2'h1;
  localparam logic [3:0] PSC_SRC_MASK = 4'hF;
  localparam logic [3:0] PSC_SRC_RESET = 4'h0;
  localparam logic [1:0] DIV4_LAST    = 2'h3;

  // Flag and enable bit positions (flag bit n pairs with enable bit n)
  localparam int BIT_TB0    = 0;
  localparam int BIT_TB1    = 1;
  localparam int BIT_SERIAL = 2;
  localparam int BIT_UART   = 3;
  localparam int BIT_MF0    = 4;
  localparam int BIT_MF1    = 5;
  localparam int BIT_MF2    = 6;
  localparam int BIT_TM0A   = 7;
  localparam int BIT_TM0P   = 8;
  localparam int BIT_TM1A   = 9;
  localparam int BIT_TM1P   = 10;
  localparam int BIT_LOWSUP = 11;
  localparam int BIT_NVM    = 12;
  localparam int BIT_GLOBAL = 15;
  localparam logic [15:0] FLAG_MASK    = 16'h1FFF;
  localparam logic [15:0] ENABLE_MASK  = 16'h9FFF;
  localparam logic [15:0] FLAG_RESET   = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Vectors; lower code means higher priority
  typedef enum logic [2:0] {
    VEC_TB0    = 3'h0,
    VEC_TB1    = 3'h1,
    VEC_SERIAL = 3'h2,
    VEC_UART   = 3'h3,
    VEC_MF0    = 3'h4,
    VEC_MF1    = 3'h5,
    VEC_MF2    = 3'h6,
    VEC_NONE   = 3'h7
  } vector_e;

endpackage

// *** testbench/irq_timebase_props.sv ***
// Port-level checker of the interrupt and time base block.
// Assumes it is bound onto irq_timebase and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module irq_timebase_props (
  // Clock, reset, clock enable
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  // Register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Core side
  input wire logic        instr_boundary,
  input wire logic        stack_full,
  input wire logic        return_from_irq,
  input wire logic        plain_return,
  input wire logic        vector_call,
  input wire logic [2:0]  vector_id,
  input wire logic        pc_pop
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Either return instruction from the core
  sequence s_ret;
    return_from_irq || plain_return;
  endsequence
  // Stack pop one cycle later
  sequence s_pop;
    ##1 pc_pop;
  endsequence
  a_ret_pops: assert property (s_ret |-> s_pop)
    else $error("return without stack pop");
  a_pop_cause: assert property (
    pc_pop |-> $past(return_from_irq || plain_return))
    else $error("stack pop without return");
  a_call_gate: assert property (
    vector_call |-> $past(instr_boundary && !stack_full))
    else $error("vector call without boundary or with full stack");
  a_call_single: assert property (vector_call |=> !vector_call)
    else $error("vector call longer than one cycle");
  a_id_steady: assert property (!vector_call |-> $stable(vector_id))
    else $error("vector id moved without a call");
  a_ready_frozen: assert property (
    !clk_en |-> !awready && !wready && !arready)
    else $error("ready while clock enable low");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped before taken");
endmodule
`default_nettype wire

// *** testbench/core_model.sv ***
// Behavioural processor core: boundaries, stack depth, return pulses.
// Assumes the block's one-cycle vector_call; the bench steers returns.
`timescale 1ns/1ps
`default_nettype none
module core_model #(
  parameter int DEPTH = 8  // Stack levels
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Block side
  input  wire logic vector_call,
  output logic      instr_boundary,
  output logic      stack_full,
  output logic      return_from_irq,
  output logic      plain_return,
  // Bench steering
  input  wire logic full_req,
  input  wire logic plain_sel,
  input  wire logic auto_ret
);
  int         depth_q;         // Levels in use
  int         wait_q;          // Cycles left in handler
  logic [1:0] phase_q = 2'h0;  // Boundary pacing
  // Full when all levels used, or when the bench asks
  assign stack_full = full_req || (depth_q >= DEPTH);
  // Handler timing; a boundary is missed one cycle in four
  always @(posedge aclk) begin
    return_from_irq <= 1'b0;
    plain_return    <= 1'b0;
    phase_q         <= phase_q + 2'h1;
    instr_boundary  <= (phase_q != 2'h3) && aresetn;
    if (!aresetn) begin
      depth_q <= 0;
      wait_q  <= 0;
    end else if (vector_call) begin
      // Only the program counter is pushed
      depth_q <= depth_q + 1;
      wait_q  <= 4;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end else if (wait_q == 1 && auto_ret) begin
      // Leave by one of the two returns
      depth_q         <= depth_q - 1;
      wait_q          <= 0;
      return_from_irq <= !plain_sel;
      plain_return    <= plain_sel;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench of the interrupt and time base block.
// Assumes package, design, core model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, sub_clk = 1'b0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [14:0] ev = 15'h0;  // Event pulses of all sources
  logic        full_req = 0, plain_sel = 0, auto_ret = 1;
  logic        awready, wready, bvalid, arready, rvalid, vector_call;
  logic        pc_pop, wake_req, instr_boundary, stack_full;
  logic        return_from_irq, plain_return, seen;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, m;
  logic [2:0]  vector_id;
  int          mismatches = 0, check_count = 0;
  int          seed = 32'hcb438b27;
  // Flag bit and group bit of each event line
  int fbit[15] = '{7, 9, 8, 10, 2, 2, 2, 3, 3, 3, 3, 3, 3, 11, 12};
  int gbit[15] = '{4, 5, 4, 5, 0, 0, 0, 0, 0, 0, 0, 0, 0, 6, 6};
  // System clock and an unrelated sub clock
  always #20 aclk = ~aclk;
  always #125 sub_clk = ~sub_clk;
  irq_timebase dut (.*, .awprot(3'h0), .arprot(3'h0), .wstrb(4'hF),
    .tm_match_a(ev[1:0]), .tm_match_p(ev[3:2]), .serial_if_event(ev[6:4]),
    .uart_event(ev[12:7]), .low_supply_detect(ev[13]),
    .nvm_cycle_done(ev[14]));
  core_model core (.*);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus write; both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic at, wt, ta, tw, bv;
    at = 0;
    wt = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(at && wt)) begin
      @(negedge aclk) ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      at |= ta;
      wt |= tw;
    end
    // Response stands a cycle with bready low, then is taken
    do begin
      @(negedge aclk) bv = bvalid;
      @(posedge aclk);
    end while (!bv);
    bready <= 1;
    @(negedge aclk) r = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask
  task automatic wrw(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("write response", irq_tb_pkg::RESP_OKAY, 32'(r));
  endtask
  // Bus read with data and response checked
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    logic tk, rv;
    logic [1:0] r;
    logic [31:0] d;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(negedge aclk) tk = arready;
      @(posedge aclk);
    end while (!tk);
    arvalid <= 0;
    // Read data stands a cycle with rready low, then is taken
    @(posedge aclk);
    rready <= 1;
    do begin
      @(negedge aclk) rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!rv);
    rready <= 0;
    chk($sformatf("read data at %h", a), e, d);
    chk("read response", 32'(er), 32'(r));
  endtask
  // Watch 20 cycles for a vector call or a stack pop
  task automatic watch(input logic pop, output logic s);
    s = 0;
    repeat (20) @(negedge aclk) s |= pop ? pc_pop : vector_call;
    @(posedge aclk);
  endtask
  // Cycles from run to time-out for a code and source
  function automatic int span(input int code, input int src);
    return (1 << (8 + code)) * (src > 1 ? 25 : src == 1 ? 16 : 4) / 4;
  endfunction
  // Start a time base, time its wake pulse, check and clear its flag
  task automatic tb_time(input int idx, input int code, input int src);
    int n, e;
    logic [7:0] ofs;
    ofs = idx ? irq_tb_pkg::OFS_TB1_CTRL : irq_tb_pkg::OFS_TB0_CTRL;
    e = span(code, src);
    n = 0;
    wrw(ofs, 32'h80 | code);
    do @(negedge aclk) n++; while (!wake_req && n < e + 40);
    @(posedge aclk);
    chk("time-out cycles", e, (n > e - 12 && n < e + 12) ? e : n);
    rdchk(irq_tb_pkg::OFS_FLAG, 32'h1 << idx, 2'h0);
    wrw(ofs, 32'h0);
    wrw(irq_tb_pkg::OFS_FLAG, 32'h1FFF);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog sized above the longest time-out sweep
  initial begin
    #(95000 * 40);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    clk_en <= 0;
    repeat (3) @(posedge aclk);
    clk_en <= 1;
    // Reset values, unmapped place, implemented control bits
    for (int a = 0; a < 24; a += 4) rdchk(8'(a), 32'h0, 2'h0);
    rdchk(8'h20, 32'h0, irq_tb_pkg::RESP_SLVERR);
    wr(8'h20, 32'hFFFF, resp);
    chk("unmapped write", irq_tb_pkg::RESP_SLVERR, 32'(resp));
    wrw(irq_tb_pkg::OFS_TB0_CTRL, 32'h7F);
    repeat (300) @(posedge aclk);
    rdchk(irq_tb_pkg::OFS_FLAG, 32'h0, 2'h0);
    rdchk(irq_tb_pkg::OFS_TB0_CTRL, 32'h07, 2'h0);
    $display("test registers done");
    // Every period code, then every prescaler source
    for (int c = 0; c < 8; c++) tb_time(0, c, 0);
    for (int s = 1; s < 4; s++) begin
      wrw(irq_tb_pkg::OFS_PSC_SRC, 32'(s << 2));
      tb_time(1, 0, s);
    end
    $display("test time base done");
    // Each event line: masked, stack full, vectored, returned
    for (int k = 0; k < 15; k++) begin
      m = (32'h1 << fbit[k]) | (gbit[k] ? 32'h1 << gbit[k] : 32'h0);
      auto_ret <= 0;
      plain_sel <= k[0];
      full_req <= 1;
      wrw(irq_tb_pkg::OFS_ENABLE, m);
      ev <= 15'(1 << k);
      @(posedge aclk);
      ev <= 15'h0;
      watch(0, seen);
      chk("call without global", 0, 32'(seen));
      rdchk(irq_tb_pkg::OFS_FLAG, m, 2'h0);
      wrw(irq_tb_pkg::OFS_ENABLE, m | 32'h8000);
      watch(0, seen);
      chk("call with full stack", 0, 32'(seen));
      full_req <= 0;
      watch(0, seen);
      chk("call", 1, 32'(seen));
      chk("vector", gbit[k] ? gbit[k] : fbit[k], 32'(vector_id));
      rdchk(irq_tb_pkg::OFS_FLAG, gbit[k] ? 32'h1 << fbit[k] : 0,
            2'h0);
      rdchk(irq_tb_pkg::OFS_ENABLE, m, 2'h0);
      auto_ret <= 1;
      watch(1, seen);
      chk("stack pop", 1, 32'(seen));
      rdchk(irq_tb_pkg::OFS_ENABLE, m | (k[0] ? 0 : 32'h8000),
            2'h0);
      wrw(irq_tb_pkg::OFS_ENABLE, 32'h0);
      wrw(irq_tb_pkg::OFS_FLAG, 32'h1FFF);
    end
    $display("test vectoring done");
    // A preset flag keeps its source from waking the device
    // Member and group flags preset, so the event raises no flag
    wrw(irq_tb_pkg::OFS_FLAG_SET, 32'h1040);
    ev <= 15'h4000;
    @(posedge aclk);
    ev <= 15'h0;
    repeat (3) @(negedge aclk)
      chk("wake on set flag", 0, 32'(wake_req));
    @(posedge aclk);
    wrw(irq_tb_pkg::OFS_FLAG, 32'h1FFF);
    // Random sets of pending sources, lowest code wins
    auto_ret <= 0;
    for (int i = 0; i < 6; i++) begin
      m = $random(seed) & 32'hF;
      if (m == 0) m = 32'hC;
      wrw(irq_tb_pkg::OFS_FLAG_SET, m);
      wrw(irq_tb_pkg::OFS_ENABLE, 32'h800F);
      watch(0, seen);
      chk("priority call", 1, 32'(seen));
      chk("priority vector", m[0] ? 0 : m[1] ? 1 : m[2] ? 2 : 3,
          32'(vector_id));
      wrw(irq_tb_pkg::OFS_ENABLE, 32'h0);
      wrw(irq_tb_pkg::OFS_FLAG, 32'h1FFF);
    end
    $display("test priority done");
    report_and_stop();
  end
endmodule
bind irq_timebase irq_timebase_props props (.*);
`default_nettype wire
